// ### hw/load_ind_pkg.sv
package load_ind_pkg;

  // Core clock and the settling time after a coil polarity change.
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned UPD_SETTLE_NS   = 8000;
  localparam int unsigned UPD_SETTLE_CYC  = (UPD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_CNT      = 8'(UPD_SETTLE_CYC);

  // Serial word size and load indicator width.
  localparam int unsigned WORD_W          = 12;
  localparam int unsigned LOAD_W          = 3;

  // Command word fields.
  localparam int unsigned CMD_MDA         = 11;
  localparam int unsigned CMD_CA_MSB      = 10;
  localparam int unsigned CMD_CA_LSB      = 7;
  localparam int unsigned CMD_PHA         = 6;
  localparam int unsigned CMD_MDB         = 5;
  localparam int unsigned CMD_CB_MSB      = 4;
  localparam int unsigned CMD_CB_LSB      = 1;
  localparam int unsigned CMD_PHB         = 0;

  // Status word: load level on top, a constant one, then eight fault flags.
  localparam logic        ST_ONE          = 1'b1;

  // Meaning of load levels: low value means heavy load.
  localparam logic [2:0]  LOAD_STALL      = 3'h0;
  localparam logic [2:0]  LOAD_HIGH_MAX   = 3'h2;
  localparam logic [2:0]  LOAD_LIGHT_MIN  = 3'h3;
  localparam logic [2:0]  LOAD_LOWEST     = 3'h7;

  // Register map, byte addresses.
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_CMD         = 8'h08;

  // Control register fields and reset value.
  localparam int unsigned CTRL_EXT_POS    = 0;
  localparam int unsigned CTRL_DIV_LSB    = 8;
  localparam int unsigned CTRL_DIV_MSB    = 15;
  localparam logic [31:0] CTRL_RST        = 32'h0000_1000;

  // Status register fields.
  localparam int unsigned STS_VALID_POS   = 3;
  localparam int unsigned STS_SERIAL_POS  = 4;
  localparam int unsigned STS_EN_POS      = 5;
  localparam int unsigned STS_AREF_POS    = 6;
  localparam int unsigned STS_BL_LSB      = 7;
  localparam int unsigned STS_XFER_POS    = 9;

  // Pin synchroniser reset: chip select, enable and reference select idle high.
  localparam logic [8:0]  PIN_SYNC_RST    = 9'h023;

  // Blanking length in core cycles for each select code.
  localparam logic [2:0]  BLANK_CYC_0     = 3'h1;
  localparam logic [2:0]  BLANK_CYC_1     = 3'h2;
  localparam logic [2:0]  BLANK_CYC_2     = 3'h3;
  localparam logic [2:0]  BLANK_CYC_3     = 3'h4;

  // Saturation of the mixed-decay-off microstep counters.
  localparam logic [1:0]  MD_OFF_SAT      = 2'h3;

  typedef enum logic [1:0] {UPD_IDLE, UPD_CHOP, UPD_SETTLE} upd_state_t;

endpackage

// ### hw/stall_load_indicator.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Three-bit unsigned load level readable over the serial link during motion.
// - Load level refreshed once per fullstep and held in between.
// - Level falls as load rises; zero is heaviest, seven is lightest.
// - Higher load never gives a higher reading at equal mixed decay; stalled motor reads jumpy values.
// - Mixed decay kept closer to zero crossing gives a lower reported level.
// - Level may be invalid one chopper period plus 8 us after polarity toggle.
// - Serial control only while serial mode select is high.
// - Device runs only while enable is low; the pin also shuts down.
// - Low reference select makes coil currents follow the analog reference inputs.
// - Serial data output driven only during a selected transfer.
// - Two blank-time selects set the current-sense blanking interval.
// - Chopper clocked by internal oscillator or external clock on oscillator pin.
// - Each transfer swaps a twelve-bit command for a twelve-bit status word.
// - Load level occupies status bits eleven down to nine.
module stall_load_indicator (
  input  wire logic        core_clk_i,            // Core clock, 20 MHz.
  input  wire logic        rst_i,                 // Synchronous reset, active high.
  input  wire logic [7:0]  reg_addr_i,            // Register byte address.
  input  wire logic [31:0] reg_wdata_i,           // Register write data.
  input  wire logic        reg_wr_i,              // Write strobe.
  input  wire logic        reg_rd_i,              // Read strobe.
  output logic      [31:0] reg_rdata_o,           // Read data, one cycle after strobe.
  input  wire logic        sck_i,                 // Serial clock pin.
  input  wire logic        cs_n_i,                // Serial chip select pin, active low.
  input  wire logic        sdi_i,                 // Serial data in pin.
  output logic             serial_data_out_o,     // Serial data out level.
  output logic             serial_data_out_oe_o,  // Serial data out enable.
  input  wire logic        serial_mode_select_i,  // Serial mode select pin.
  input  wire logic        chip_enable_n_i,       // Device enable pin, active low.
  input  wire logic        analog_ref_select_n_i, // Analog reference select, active low.
  input  wire logic        blank_time_sel_0_i,    // Blank time select, low bit.
  input  wire logic        blank_time_sel_1_i,    // Blank time select, high bit.
  input  wire logic        chopper_clock_input_i, // External chopper clock pin.
  input  wire logic [2:0]  load_raw_i,            // Quantised back-EMF load sample.
  input  wire logic [7:0]  diag_flags_i,          // Fault flags for the status word.
  output logic             mixed_decay_coil_a_o,  // Mixed decay coil A.
  output logic             polarity_coil_a_o,     // Polarity coil A.
  output logic      [3:0]  current_coil_a_o,      // Current setting coil A.
  output logic             mixed_decay_coil_b_o,  // Mixed decay coil B.
  output logic             polarity_coil_b_o,     // Polarity coil B.
  output logic      [3:0]  current_coil_b_o,      // Current setting coil B.
  output logic             analog_ref_mode_o,     // Currents follow analog references.
  output logic             driver_enable_o,       // Device enabled.
  output logic             serial_mode_o,         // Serial control active.
  output logic             chop_tick_o,           // One-cycle chopper period pulse.
  output logic             blank_o,               // Current-sense blanking active.
  output logic      [2:0]  load_level_o,          // Current load level.
  output logic             load_valid_o           // Load level settled.
);

  // Two-flop synchronisers for every pin; third stage only for edge finding.
  logic [8:0]  pin_s1_q;
  logic [8:0]  pin_s2_q;
  logic [2:0]  edge_prev_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_q <= load_ind_pkg::PIN_SYNC_RST;
      pin_s2_q <= load_ind_pkg::PIN_SYNC_RST;
    end else begin
      pin_s1_q <= {chopper_clock_input_i, blank_time_sel_1_i, blank_time_sel_0_i,
                   analog_ref_select_n_i, serial_mode_select_i, sdi_i, sck_i,
                   chip_enable_n_i, cs_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic        csn_s, enn_s, sck_s, sdi_s, spe_s, ann_s, chop_s;
  logic [1:0]  bl_s;

  // Named views of the synchronised pins, in the order the first stage packs them.
  assign {chop_s, bl_s, ann_s, spe_s, sdi_s, sck_s, enn_s, csn_s} = pin_s2_q;

  // Edge history of chip select, serial clock and external chopper clock.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      edge_prev_q <= 3'h1;
    end else begin
      edge_prev_q <= {chop_s, sck_s, csn_s};
    end
  end

  logic        enabled, serial_on, cs_fall, cs_rise, sck_rise, sck_fall, chop_rise;

  // The enable pin gates all but the pin synchronisers, edge history, register port and control register; serial transfers also need mode select.
  assign enabled   = ~enn_s;
  assign serial_on = enabled & spe_s;
  assign cs_fall   = edge_prev_q[0] & ~csn_s;
  assign cs_rise   = ~edge_prev_q[0] & csn_s;
  assign sck_rise  = ~edge_prev_q[1] & sck_s;
  assign sck_fall  = edge_prev_q[1] & ~sck_s;
  assign chop_rise = ~edge_prev_q[2] & chop_s;

  // Registered mode outputs.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      driver_enable_o   <= 1'b0;
      serial_mode_o     <= 1'b0;
      analog_ref_mode_o <= 1'b0;
    end else begin
      driver_enable_o   <= enabled;
      serial_mode_o     <= serial_on;
      analog_ref_mode_o <= enabled & ~ann_s;
    end
  end

  // Control register: chopper source and internal oscillator divider.
  logic [31:0] ctrl_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= load_ind_pkg::CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == load_ind_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  // Chopper timebase; a divider of zero stops the internal oscillator.
  logic [7:0]  osc_cnt_q, osc_div;
  logic        osc_wrap, ext_sel, chop_tick;

  assign osc_div   = ctrl_q[load_ind_pkg::CTRL_DIV_MSB:load_ind_pkg::CTRL_DIV_LSB];
  assign ext_sel   = ctrl_q[load_ind_pkg::CTRL_EXT_POS];
  assign osc_wrap  = (osc_div != 8'h00) && (osc_cnt_q >= osc_div - 8'h01);
  assign chop_tick = enabled & (ext_sel ? chop_rise : osc_wrap);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled || ext_sel || osc_wrap) begin
      osc_cnt_q <= 8'h00;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end

  // Blanking after each chopper period start, length picked by the select pins.
  logic [2:0]  blank_cnt_q, blank_len, blank_cnt_d;

  always_comb begin
    unique case (bl_s)
      2'h0: blank_len = load_ind_pkg::BLANK_CYC_0;
      2'h1: blank_len = load_ind_pkg::BLANK_CYC_1;
      2'h2: blank_len = load_ind_pkg::BLANK_CYC_2;
      2'h3: blank_len = load_ind_pkg::BLANK_CYC_3;
    endcase
    if (chop_tick) begin
      blank_cnt_d = blank_len;
    end else if (blank_cnt_q != 3'h0) begin
      blank_cnt_d = blank_cnt_q - 3'h1;
    end else begin
      blank_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      blank_cnt_q <= 3'h0;
      blank_o     <= 1'b0;
      chop_tick_o <= 1'b0;
    end else begin
      blank_cnt_q <= blank_cnt_d;
      blank_o     <= blank_cnt_d != 3'h0;
      chop_tick_o <= chop_tick;
    end
  end

  // Serial shift path; fed bits reappear twelve clocks later for daisy chains.
  logic [11:0] shift_q;
  logic        xfer_q;
  logic [11:0] status_word;

  assign status_word = {load_level_o, load_ind_pkg::ST_ONE, diag_flags_i};

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !serial_on) begin
      shift_q              <= 12'h000;
      xfer_q               <= 1'b0;
      serial_data_out_o    <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
    end else if (cs_fall) begin
      shift_q              <= status_word;
      xfer_q               <= 1'b1;
      serial_data_out_o    <= status_word[load_ind_pkg::WORD_W-1];
      serial_data_out_oe_o <= 1'b1;
    end else if (xfer_q && cs_rise) begin
      xfer_q               <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
    end else if (xfer_q && sck_rise) begin
      shift_q              <= {shift_q[10:0], sdi_s};
    end else if (xfer_q && sck_fall) begin
      serial_data_out_o    <= shift_q[load_ind_pkg::WORD_W-1];
    end
  end

  // Command latch on chip select release; disable clears it to zero.
  logic [11:0] cmd_q;
  logic        cmd_take;

  assign cmd_take = serial_on & xfer_q & cs_rise;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      cmd_q <= 12'h000;
    end else if (cmd_take) begin
      cmd_q <= shift_q;
    end
  end

  assign mixed_decay_coil_a_o = cmd_q[load_ind_pkg::CMD_MDA];
  assign polarity_coil_a_o    = cmd_q[load_ind_pkg::CMD_PHA];
  assign current_coil_a_o     = cmd_q[load_ind_pkg::CMD_CA_MSB:load_ind_pkg::CMD_CA_LSB];
  assign mixed_decay_coil_b_o = cmd_q[load_ind_pkg::CMD_MDB];
  assign polarity_coil_b_o    = cmd_q[load_ind_pkg::CMD_PHB];
  assign current_coil_b_o     = cmd_q[load_ind_pkg::CMD_CB_MSB:load_ind_pkg::CMD_CB_LSB];

  // A polarity toggle on either coil marks a fullstep boundary.
  logic        tog_a, tog_b, fullstep;

  assign tog_a    = shift_q[load_ind_pkg::CMD_PHA] ^ cmd_q[load_ind_pkg::CMD_PHA];
  assign tog_b    = shift_q[load_ind_pkg::CMD_PHB] ^ cmd_q[load_ind_pkg::CMD_PHB];
  assign fullstep = cmd_take & (tog_a | tog_b);

  // Microsteps each coil has run with mixed decay off, saturating.
  logic [1:0]  md_off_a_q, md_off_b_q, pen_steps_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      md_off_a_q <= 2'h0;
      md_off_b_q <= 2'h0;
    end else if (cmd_take) begin
      if (shift_q[load_ind_pkg::CMD_MDA]) begin
        md_off_a_q <= 2'h0;
      end else if (md_off_a_q != load_ind_pkg::MD_OFF_SAT) begin
        md_off_a_q <= md_off_a_q + 2'h1;
      end
      if (shift_q[load_ind_pkg::CMD_MDB]) begin
        md_off_b_q <= 2'h0;
      end else if (md_off_b_q != load_ind_pkg::MD_OFF_SAT) begin
        md_off_b_q <= md_off_b_q + 2'h1;
      end
    end
  end

  // Lead time of the crossing coil before its toggle; shortest one counts.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      pen_steps_q <= 2'h0;
    end else if (fullstep) begin
      if (tog_a && tog_b) begin
        pen_steps_q <= (md_off_a_q < md_off_b_q) ? md_off_a_q : md_off_b_q;
      end else begin
        pen_steps_q <= tog_a ? md_off_a_q : md_off_b_q;
      end
    end
  end

  // Update sequence: wait one chopper edge, then the settle time, then sample.
  // The reading is flagged invalid meanwhile, since the back-EMF path is settling.
  load_ind_pkg::upd_state_t upd_q;
  logic [7:0]  settle_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      upd_q    <= load_ind_pkg::UPD_IDLE;
      settle_q <= 8'h00;
    end else if (fullstep) begin
      upd_q    <= load_ind_pkg::UPD_CHOP;
      settle_q <= 8'h00;
    end else begin
      unique case (upd_q)
        load_ind_pkg::UPD_IDLE: begin
          settle_q <= 8'h00;
        end
        load_ind_pkg::UPD_CHOP: begin
          if (chop_tick) begin
            upd_q <= load_ind_pkg::UPD_SETTLE;
          end
        end
        load_ind_pkg::UPD_SETTLE: begin
          if (settle_q == load_ind_pkg::SETTLE_CNT - 8'h01) begin
            upd_q <= load_ind_pkg::UPD_IDLE;
          end else begin
            settle_q <= settle_q + 8'h01;
          end
        end
        default: begin
          upd_q <= load_ind_pkg::UPD_IDLE;
        end
      endcase
    end
  end

  logic        sample_now;
  logic [2:0]  load_scaled;

  assign sample_now = (upd_q == load_ind_pkg::UPD_SETTLE) &&
                      (settle_q == load_ind_pkg::SETTLE_CNT - 8'h01) && !fullstep;

  // Mixed decay too close to the crossing weakens the signal; shift keeps order.
  always_comb begin
    unique case (pen_steps_q)
      2'h0:    load_scaled = load_raw_i >> 2;
      2'h1:    load_scaled = load_raw_i >> 1;
      default: load_scaled = load_raw_i;
    endcase
  end

  // Level held between fullsteps; raw sample is monotone in load.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enabled) begin
      load_level_o <= load_ind_pkg::LOAD_STALL;
      load_valid_o <= 1'b0;
    end else if (fullstep) begin
      load_valid_o <= 1'b0;
    end else if (sample_now) begin
      load_level_o <= load_scaled;
      load_valid_o <= 1'b1;
    end
  end

  // Register read port; unmapped addresses read zero.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      unique case (reg_addr_i)
        load_ind_pkg::REG_CTRL: begin
          reg_rdata_o <= ctrl_q;
        end
        load_ind_pkg::REG_STATUS: begin
          reg_rdata_o[2:0]                           <= load_level_o;
          reg_rdata_o[load_ind_pkg::STS_VALID_POS]   <= load_valid_o;
          reg_rdata_o[load_ind_pkg::STS_SERIAL_POS]  <= serial_mode_o;
          reg_rdata_o[load_ind_pkg::STS_EN_POS]      <= driver_enable_o;
          reg_rdata_o[load_ind_pkg::STS_AREF_POS]    <= analog_ref_mode_o;
          reg_rdata_o[load_ind_pkg::STS_BL_LSB +: 2] <= bl_s;
          reg_rdata_o[load_ind_pkg::STS_XFER_POS]    <= xfer_q;
        end
        load_ind_pkg::REG_CMD: begin
          reg_rdata_o[11:0] <= cmd_q;
        end
        default: begin
          reg_rdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// ### tb/stall_load_monitor.sv
`timescale 1ns/1ns
// Pin-level checks on the load indicator block, all in the core clock domain.
module stall_load_monitor (
  input wire logic        core_clk_i,            // Core clock.
  input wire logic        rst_i,                 // Reset.
  input wire logic [7:0]  reg_addr_i,            // Address.
  input wire logic        reg_rd_i,              // Read strobe.
  input wire logic [31:0] reg_rdata_o,           // Read data.
  input wire logic        cs_n_i,                // Chip select.
  input wire logic        serial_data_out_o,     // Data out.
  input wire logic        serial_data_out_oe_o,  // Data out enable.
  input wire logic        chip_enable_n_i,       // Enable pin.
  input wire logic [2:0]  load_raw_i,            // Raw load.
  input wire logic        polarity_coil_a_o,     // Polarity A.
  input wire logic        polarity_coil_b_o,     // Polarity B.
  input wire logic        driver_enable_o,       // Enabled.
  input wire logic        serial_mode_o,         // Serial mode.
  input wire logic [2:0]  load_level_q,          // Load level.
  input wire logic        load_valid_o           // Level settled.
);
  logic [8:0] low_cnt_q;
  logic       armed_q;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Counts consecutive low cycles of the valid flag, so a short settle window is caught.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || load_valid_o) low_cnt_q <= 9'h000;
    else if (low_cnt_q != 9'h1FF) low_cnt_q <= low_cnt_q + 9'h001;
  end
  // Armed only for windows opened while enabled; a disable may clear the level early.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !driver_enable_o) armed_q <= 1'b0;
    else if ($fell(load_valid_o)) armed_q <= 1'b1;
    else if (load_valid_o) armed_q <= 1'b0;
  end
  property p_oe_accept; $rose(serial_data_out_oe_o) |-> serial_mode_o && driver_enable_o; endproperty
  a_oe_accept: assert property (p_oe_accept) else $error("Data out driven while refused");
  property p_oe_release; cs_n_i [*8] |-> !serial_data_out_oe_o; endproperty
  a_oe_release: assert property (p_oe_release) else $error("Data out driven while idle");
  property p_first_bit; $rose(serial_data_out_oe_o) |-> serial_data_out_o == load_level_q[2]; endproperty
  a_first_bit: assert property (p_first_bit) else $error("First bit is not the level top bit");
  property p_level_hold;
    !$stable(load_level_q) |-> $rose(load_valid_o) || !driver_enable_o || !$past(driver_enable_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("Level changed between updates");
  property p_valid_drop;
    driver_enable_o && $past(driver_enable_o) && ($changed(polarity_coil_a_o) || $changed(polarity_coil_b_o))
      |-> ##[0:2] !load_valid_o;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("Polarity toggle did not open a window");
  property p_settle_min; $rose(load_valid_o) && armed_q |-> low_cnt_q >= {1'b0, load_ind_pkg::SETTLE_CNT}; endproperty
  a_settle_min: assert property (p_settle_min) else $error("Level settled too soon");
  property p_valid_bound; $fell(load_valid_o) && driver_enable_o |-> ##[1:1000] (load_valid_o || !driver_enable_o); endproperty
  a_valid_bound: assert property (p_valid_bound) else $error("Level never refreshed");
  property p_shift; $rose(load_valid_o) |-> load_level_q <= $past(load_raw_i); endproperty
  a_shift: assert property (p_shift) else $error("Level above raw load sample");
  property p_status_rd; reg_rd_i && reg_addr_i == load_ind_pkg::REG_STATUS |=> reg_rdata_o[2:0] == $past(load_level_q); endproperty
  a_status_rd: assert property (p_status_rd) else $error("Status read lost the level");
  property p_enable; chip_enable_n_i [*5] |-> !driver_enable_o; endproperty
  a_enable: assert property (p_enable) else $error("Enabled with enable pin high");
  c_update: cover property ($rose(load_valid_o) && armed_q);
  c_frame: cover property ($rose(serial_data_out_oe_o));
  c_refused: cover property (!serial_mode_o && $fell(cs_n_i));
endmodule
bind stall_load_indicator stall_load_monitor u_monitor (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cs_n_i(cs_n_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .chip_enable_n_i(chip_enable_n_i), .load_raw_i(load_raw_i),
  .polarity_coil_a_o(polarity_coil_a_o), .polarity_coil_b_o(polarity_coil_b_o),
  .driver_enable_o(driver_enable_o), .serial_mode_o(serial_mode_o),
  .load_level_q(load_level_o), .load_valid_o(load_valid_o)
);

// ### tb/serial_master_model.sv
`timescale 1ns/1ns
// Motion controller side of the serial link: swaps one command for one status word.
module serial_master_model (
  input  wire logic clk_i,    // Core clock, paces the link.
  input  wire logic sdo_i,    // Data out level.
  input  wire logic sdo_oe_i, // Data out enable.
  output logic      sck_o,    // Serial clock, still between frames.
  output logic      cs_n_o,   // Chip select, active low.
  output logic      sdi_o     // Command data.
);
  logic last_q = 1'b0;
  logic line;
  // A released line shows the inverse of its last level, so a stale bit never reads as good.
  assign line = sdo_oe_i ? sdo_i : ~last_q;
  always @(posedge clk_i) if (sdo_oe_i) last_q <= sdo_i;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Twelve bits each way, top bit first, 400 ns per bit; data is read just before each fall.
  task automatic xfer(input logic [11:0] cmd, output logic [11:0] st, output logic oe_all);
    oe_all = 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 11; i >= 0; i--) begin
      sdi_o <= cmd[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      st[i] = line;
      oe_all = oe_all & sdo_oe_i;
      @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
// Bench for the load indicator block; the master model plays the motion controller.
module tb_top;
  logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, sck, cs_n, sdi, sdo, sdo_oe, oe_all;
  logic        sel, en_n, aref_n, bl0, bl1, chop_in, ext_run, md_a, pol_a, md_b, pol_b, aref_mode, drv_en, ser_mode;
  logic        tick, valid, blank;
  logic [7:0]  reg_addr_i, diag;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [3:0]  cur_a, cur_b;
  logic [4:0]  ext_cnt;
  logic [2:0]  load_raw, level;
  logic [11:0] st;
  int          errors, tests_run, ticks, blanks;
  stall_load_indicator u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi), .serial_data_out_o(sdo),
    .serial_data_out_oe_o(sdo_oe), .serial_mode_select_i(sel), .chip_enable_n_i(en_n), .analog_ref_select_n_i(aref_n),
    .blank_time_sel_0_i(bl0), .blank_time_sel_1_i(bl1), .chopper_clock_input_i(chop_in), .load_raw_i(load_raw),
    .diag_flags_i(diag), .mixed_decay_coil_a_o(md_a), .polarity_coil_a_o(pol_a), .current_coil_a_o(cur_a),
    .mixed_decay_coil_b_o(md_b), .polarity_coil_b_o(pol_b), .current_coil_b_o(cur_b), .analog_ref_mode_o(aref_mode),
    .driver_enable_o(drv_en), .serial_mode_o(ser_mode), .chop_tick_o(tick), .blank_o(blank), .load_level_o(level),
    .load_valid_o(valid));
  serial_master_model u_master (.clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .cs_n_o(cs_n),
    .sdi_o(sdi));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // External chopper clock, 40 core cycles a period while running; ticks are counted for the check.
  always @(posedge core_clk_i) begin
    ext_cnt <= ext_cnt + 5'h01;
    if (ext_run && ext_cnt >= 5'h13) begin
      ext_cnt <= 5'h00;
      chop_in <= ~chop_in;
    end
    if (tick === 1'b1) ticks++;
    if (blank === 1'b1) blanks++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks start just after an edge and leave one idle cycle, so no strobe is set twice at once.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i); #1;
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i); #1;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i); #1;
    reg_rd_i <= 1'b0;
    chk(reg_rdata_o & m, exp);
    @(posedge core_clk_i); #1;
  endtask
  // One frame; the status is only compared when the block is expected to answer.
  task automatic send(input logic [11:0] c, input logic [11:0] exp, input logic exp_oe);
    u_master.xfer(c, st, oe_all);
    chk(32'(oe_all), 32'(exp_oe));
    if (exp_oe) chk(32'(st), 32'(exp));
  endtask
  task automatic wait_valid;
    for (int n = 0; n < 1000 && valid !== 1'b1; n++) begin
      @(posedge core_clk_i); #1;
    end
    chk(32'(valid), 32'h1);
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    complete_run();
  end
  initial begin
    {rst_i, sel, en_n, aref_n, bl1} = 5'h1F;
    {reg_wr_i, reg_rd_i, bl0, chop_in, ext_run} = 5'h00;
    {reg_addr_i, reg_wdata_i, ext_cnt} = 45'h0;
    load_raw = 3'h5;
    diag = 8'hA5;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i); #1;
    reg_read(load_ind_pkg::REG_CTRL, 32'hFFFFFFFF, load_ind_pkg::CTRL_RST);
    reg_read(8'h0C, 32'hFFFFFFFF, 32'h0);
    reg_write(load_ind_pkg::REG_CMD, 32'hFFF);
    reg_read(load_ind_pkg::REG_CMD, 32'hFFF, 32'h0);
    send(12'hFFF, 12'h0, 1'b0);
    en_n <= 1'b0;
    sel <= 1'b0;
    repeat (6) @(posedge core_clk_i); #1;
    send(12'hFFF, 12'h0, 1'b0);
    chk(32'({ser_mode, md_a, cur_a, pol_a}), 32'h0);
    sel <= 1'b1;
    aref_n <= 1'b0;
    repeat (6) @(posedge core_clk_i); #1;
    chk(32'({drv_en, ser_mode, aref_mode}), 32'h7);
    send(12'hFA0, 12'h1A5, 1'b1);
    chk(32'({md_a, cur_a, pol_a, md_b, cur_b, pol_b}), 32'hFA0);
    send(12'hFE0, 12'h1A5, 1'b1);
    chk(32'({valid, level}), 32'h0);
    wait_valid();
    chk(32'(level), 32'h1);
    send(12'hFE0, 12'h3A5, 1'b1);
    send(12'hFE0, 12'h3A5, 1'b1);
    chk(32'(st[11:9] <= load_ind_pkg::LOAD_HIGH_MAX), 32'h1);
    load_raw <= 3'h6;
    repeat (3) send(12'h7E0, 12'h3A5, 1'b1);
    chk(32'(level), 32'h1);
    send(12'h7A0, 12'h3A5, 1'b1);
    wait_valid();
    chk(32'(level), 32'h6);
    send(12'h7A0, 12'hDA5, 1'b1);
    chk(32'({md_a, cur_a, pol_a, md_b, cur_b, pol_b}), 32'h7A0);
    reg_read(load_ind_pkg::REG_STATUS, 32'h3FF, 32'h17E);
    send(12'hFA0, 12'hDA5, 1'b1);
    send(12'h7A0, 12'hDA5, 1'b1);
    send(12'h7E0, 12'hDA5, 1'b1);
    wait_valid();
    chk(32'(level), 32'h3);
    reg_write(load_ind_pkg::REG_CTRL, 32'h1);
    reg_read(load_ind_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h1);
    ext_run <= 1'b1;
    ticks = 0;
    blanks = 0;
    repeat (200) @(posedge core_clk_i); #1;
    chk(32'(ticks > 0), 32'h1);
    ext_run <= 1'b0;
    repeat (10) @(posedge core_clk_i); #1;
    chk(32'(blanks), 32'(ticks * load_ind_pkg::BLANK_CYC_2));
    ticks = 0;
    repeat (200) @(posedge core_clk_i); #1;
    chk(32'(ticks), 32'h0);
    en_n <= 1'b1;
    repeat (6) @(posedge core_clk_i); #1;
    chk(32'({drv_en, md_a, level}), 32'h0);
    complete_run();
  end
endmodule
